// ===== design/bchr_pkg.sv
/*
  Shared constants and carriers for the bridge configuration header block:
  byte offsets, reset and hardwired values and the request/answer structs.
  Assumes byte-wide configuration accesses addressed by the header offset.
*/
`default_nettype none

package bchr_pkg;

  // header byte offsets
  localparam logic [7:0] OFF_LINESZ  = 8'h0c;
  localparam logic [7:0] OFF_PLT     = 8'h0d;
  localparam logic [7:0] OFF_SELFTST = 8'h0f;
  localparam logic [7:0] OFF_BAR_LO  = 8'h10;
  localparam logic [7:0] OFF_BAR_HI  = 8'h24;
  localparam logic [7:0] OFF_CIS     = 8'h28;
  localparam logic [7:0] OFF_EXPROM  = 8'h30;
  localparam logic [7:0] OFF_MINGNT  = 8'h3e;
  localparam logic [7:0] OFF_MAXLAT  = 8'h3f;
  localparam logic [7:0] OFF_PBUS    = 8'h18;
  localparam logic [7:0] OFF_SBUS    = 8'h19;
  localparam logic [7:0] OFF_SUBBUS  = 8'h1a;

  // reset and hardwired values
  localparam logic [7:0] RST_LINESZ  = 8'h00;
  localparam logic [7:0] RST_SBUS    = 8'h00;
  localparam logic [7:0] RST_SUBBUS  = 8'h00;
  localparam logic [7:0] HW_PLT      = 8'h00;
  localparam logic [7:0] HW_SELFTST  = 8'h00;
  localparam logic [7:0] HW_PBUS     = 8'h00;
  localparam logic [7:0] RD_ABSENT   = 8'h00;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bchr_cfg_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } bchr_cfg_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] bus;
  } bchr_fwd_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic type1;
  } bchr_fwd_rsp_t;

endpackage : bchr_pkg

`default_nettype wire

// ===== design/bchr_bus_route.sv
/*
  Bus-number window compare for downstream configuration requests.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module bchr_bus_route (
  input  wire logic [7:0] bus,
  input  wire logic [7:0] secBus,
  input  wire logic [7:0] subBus,
  input  wire logic       enable,
  output logic            hit,
  output logic            type1
);
  // inside [secondary, subordinate]; equal to secondary means the link itself
  always_comb begin
    hit   = enable && (bus >= secBus) && (bus <= subBus);
    type1 = hit && (bus != secBus);
  end
endmodule : bchr_bus_route

`default_nettype wire

// ===== design/bchr_regs.sv
/*
  Virtual bridge header, offsets 0ch to 1ah: cache line size, latency
  timer, self-test, bus numbers, plus decode of the bus window for
  downstream configuration requests.
  Assumes the configuration port is driven from logic on sys_clk; one
  byte access per request, answered on the next edge.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - Cache line size is an 8-bit read/write value in dwords, reset zero, steering nothing.
// - Primary latency timer reads zero always and ignores writes.
// - Self-test reads zero always and a write starts no test.
// - Neither base window of the express port exists; both read zero and drop writes.
// - The hub-link function has no base windows 10h-24h, no expansion ROM at 30h, no CIS at 28h.
// - The hub-link function leaves minimum grant and maximum latency unimplemented.
// - Primary bus number reads zero always and ignores writes.
// - Secondary bus number is read/write, reset zero, loaded by software with the lowest bus below.
// - Subordinate bus number is read/write, reset zero, loaded with the highest bus below.
module bchr_regs #(
  parameter bit HUB_LINK_FN = 1'b0  // 1: the hub-link function, no bus numbers
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire bchr_pkg::bchr_cfg_req_t cfgReq,
  output var  bchr_pkg::bchr_cfg_rsp_t cfgRsp,
  input  wire bchr_pkg::bchr_fwd_req_t fwdReq,
  output var  bchr_pkg::bchr_fwd_rsp_t fwdRsp,
  output logic [7:0]                  cacheLineSize
);
  import bchr_pkg::*;

  typedef struct packed {
    logic [7:0]    lineSize;
    logic [7:0]    secBus;
    logic [7:0]    subBus;
    bchr_cfg_rsp_t rsp;
    bchr_fwd_rsp_t fwd;
  } bchr_state_t;

  localparam bchr_state_t ST_RESET = '{
    lineSize: RST_LINESZ,
    secBus: RST_SBUS,
    subBus: RST_SUBBUS,
    rsp:    '0,
    fwd:    '0
  };

  bchr_state_t st_r;
  bchr_state_t st_nxt;
  logic        routeHit;
  logic        routeType1;
  logic        busRegsOn;

  // bus numbers only exist on the express ports
  assign busRegsOn = !HUB_LINK_FN;

  bchr_bus_route u_route (
    .bus    (fwdReq.bus),
    .secBus (st_r.secBus),
    .subBus (st_r.subBus),
    .enable (busRegsOn),
    .hit    (routeHit),
    .type1  (routeType1)
  );

  // read mux; every absent or foreign offset falls to zero
  function automatic logic [7:0] readByte(input logic [7:0] a, input bchr_state_t s,
                                          input logic bon);
    logic [7:0] d;
    d = RD_ABSENT;
    unique case (a)
      OFF_LINESZ:  d = s.lineSize;
      OFF_PLT:     d = HW_PLT;
      OFF_SELFTST: d = HW_SELFTST;
      OFF_PBUS:    d = HW_PBUS;
      OFF_SBUS:    d = bon ? s.secBus : RD_ABSENT;
      OFF_SUBBUS:  d = bon ? s.subBus : RD_ABSENT;
      default:     d = RD_ABSENT;
    endcase
    return d;
  endfunction : readByte

  // next state: answer each access on the next edge, decode forwarding
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rsp.ack   = cfgReq.valid;
    st_nxt.fwd.valid = fwdReq.valid;
    if (cfgReq.valid && !cfgReq.write) begin
      st_nxt.rsp.rdata = readByte(cfgReq.addr, st_r, busRegsOn);
    end
    // only three offsets take writes; everything else is dropped
    if (cfgReq.valid && cfgReq.write) begin
      unique case (cfgReq.addr)
        OFF_LINESZ: st_nxt.lineSize = cfgReq.wdata;
        OFF_SBUS:   if (busRegsOn) st_nxt.secBus = cfgReq.wdata;
        OFF_SUBBUS: if (busRegsOn) st_nxt.subBus = cfgReq.wdata;
        default:    st_nxt.lineSize = st_r.lineSize;
      endcase
    end
    // result held until the next request so software may sample late
    if (fwdReq.valid) begin
      st_nxt.fwd.hit   = routeHit;
      st_nxt.fwd.type1 = routeType1;
    end
  end

  // state register; reset loads constants only, so no feedback into the reset branch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign cfgRsp        = st_r.rsp;
  assign fwdRsp        = st_r.fwd;
  // exported for observation only; the block's behaviour ignores it
  assign cacheLineSize = st_r.lineSize;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wrAt(logic [7:0] a);
    cfgReq.valid && cfgReq.write && cfgReq.addr == a;
  endsequence

  sequence s_rdAt(logic [7:0] a);
    cfgReq.valid && !cfgReq.write && cfgReq.addr == a;
  endsequence

  sequence s_fwdSec;
    fwdReq.valid && busRegsOn && fwdReq.bus == st_r.secBus && st_r.secBus <= st_r.subBus;
  endsequence

  a_linesz_readback: assert property (
    s_wrAt(OFF_LINESZ) ##1 s_rdAt(OFF_LINESZ)
    |=> cfgRsp.ack && cfgRsp.rdata == $past(cfgReq.wdata, 2))
    else $error("cache line size did not read back");

  a_plt_zero: assert property (
    s_rdAt(OFF_PLT) |=> cfgRsp.ack && cfgRsp.rdata == HW_PLT)
    else $error("latency timer read nonzero");

  a_selftest_zero: assert property (
    s_wrAt(OFF_SELFTST) ##1 s_rdAt(OFF_SELFTST) |=> cfgRsp.rdata == HW_SELFTST)
    else $error("self-test read nonzero");

  a_pbus_zero: assert property (
    s_rdAt(OFF_PBUS) |=> cfgRsp.ack && cfgRsp.rdata == HW_PBUS)
    else $error("primary bus read nonzero");

  a_secbus_write: assert property (
    busRegsOn && cfgReq.valid && cfgReq.write && cfgReq.addr == OFF_SBUS
    |=> st_r.secBus == $past(cfgReq.wdata))
    else $error("secondary bus not loaded");

  a_subbus_keep: assert property (
    !(cfgReq.valid && cfgReq.write && cfgReq.addr == OFF_SUBBUS)
    |=> st_r.subBus == $past(st_r.subBus))
    else $error("subordinate bus changed without a write");

  a_route_type0: assert property (
    s_fwdSec |=> fwdRsp.valid && fwdRsp.hit && !fwdRsp.type1)
    else $error("secondary bus not sent as type 0");

  a_route_type1: assert property (
    fwdReq.valid && busRegsOn && fwdReq.bus > st_r.secBus && fwdReq.bus <= st_r.subBus
    |=> fwdRsp.hit && fwdRsp.type1)
    else $error("subordinate bus not sent as type 1");

  a_absent_zero: assert property (
    cfgReq.valid && !cfgReq.write && cfgReq.addr >= OFF_BAR_LO && cfgReq.addr <= OFF_MAXLAT
    && !(busRegsOn && (cfgReq.addr == OFF_SBUS || cfgReq.addr == OFF_SUBBUS))
    |=> cfgRsp.rdata == RD_ABSENT)
    else $error("absent location read nonzero");

  a_ack_timing: assert property (
    cfgRsp.ack |-> $past(cfgReq.valid))
    else $error("answer without a request");

  // one answer per request; read data only moves on a read
  a_ack_follow: assert property (
    cfgReq.valid |=> cfgRsp.ack)
    else $error("request left without an answer");

  a_rdata_hold: assert property (
    !(cfgReq.valid && !cfgReq.write) |=> $stable(cfgRsp.rdata))
    else $error("read data moved without a read");

  // writable bytes move only on their own write; the subordinate bus loads on its write
  a_linesz_keep: assert property (
    !(cfgReq.valid && cfgReq.write && cfgReq.addr == OFF_LINESZ)
    |=> st_r.lineSize == $past(st_r.lineSize))
    else $error("cache line size changed without a write");

  a_secbus_keep: assert property (
    !(cfgReq.valid && cfgReq.write && cfgReq.addr == OFF_SBUS)
    |=> st_r.secBus == $past(st_r.secBus))
    else $error("secondary bus changed without a write");

  a_subbus_write: assert property (
    busRegsOn && cfgReq.valid && cfgReq.write && cfgReq.addr == OFF_SUBBUS
    |=> st_r.subBus == $past(cfgReq.wdata))
    else $error("subordinate bus not loaded");

  // the hub-link variant has no bus numbers at all
  a_hub_nobus: assert property (
    !busRegsOn && cfgReq.valid && !cfgReq.write
    && (cfgReq.addr == OFF_SBUS || cfgReq.addr == OFF_SUBBUS)
    |=> cfgRsp.rdata == RD_ABSENT)
    else $error("bus number readable on the hub-link function");

  // outside the window nothing is forwarded; one answer per request
  a_fwd_miss: assert property (
    fwdReq.valid && !(busRegsOn && fwdReq.bus >= st_r.secBus && fwdReq.bus <= st_r.subBus)
    |=> fwdRsp.valid && !fwdRsp.hit && !fwdRsp.type1)
    else $error("request outside the window was forwarded");

  a_fwd_lone: assert property (
    fwdRsp.valid |-> $past(fwdReq.valid))
    else $error("forward answer without a request");

endmodule : bchr_regs

`default_nettype wire

// ===== verif/bchr_regs_bench.sv
/*
  Self-checking bench for bchr_regs: reset values, read/write and
  read-only bytes, absent offsets and the bus-window decode.
  Assumes bchr_pkg is compiled first and a 50 MHz sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module bchr_regs_bench;
  import bchr_pkg::*;

  logic          sys_clk;
  logic          rst;
  bchr_cfg_req_t cfgReq;
  bchr_cfg_rsp_t cfgRsp;
  bchr_fwd_req_t fwdReq;
  bchr_fwd_rsp_t fwdRsp;
  logic [7:0]    cacheLineSize;
  bchr_cfg_rsp_t cfgRspHub;
  bchr_fwd_rsp_t fwdRspHub;
  logic [7:0]    cacheLineSizeHub;
  int            nErrors;
  int            checksDone;
  // implemented bytes and what they read after a write of ff
  logic [7:0]    offs [6] = '{OFF_LINESZ, OFF_PLT, OFF_SELFTST, OFF_PBUS, OFF_SBUS, OFF_SUBBUS};
  logic [7:0]    wExp [6] = '{8'hff, HW_PLT, HW_SELFTST, HW_PBUS, 8'hff, 8'hff};
  // absent bytes, including both ends of the base window range
  logic [7:0]    gaps [9] = '{8'h0e, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h30, 8'h3e, 8'h3f};

  bchr_regs u_bchr_regs (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .cfgReq        (cfgReq),
    .cfgRsp        (cfgRsp),
    .fwdReq        (fwdReq),
    .fwdRsp        (fwdRsp),
    .cacheLineSize (cacheLineSize)
  );

  // hub-link variant on the same requests: no bus numbers, window never hits
  bchr_regs #(
    .HUB_LINK_FN (1'b1)
  ) u_bchr_regs_hub (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .cfgReq        (cfgReq),
    .cfgRsp        (cfgRspHub),
    .fwdReq        (fwdReq),
    .fwdRsp        (fwdRspHub),
    .cacheLineSize (cacheLineSizeHub)
  );

  // free-running clock, 20 ns period
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one byte access; ack and read data are looked at while the ack stands
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] exp);
    @(negedge sys_clk);
    cfgReq = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(negedge sys_clk);
    cfgReq.valid = 1'b0;
    chk({7'h00, cfgRsp.ack}, 8'h01);
    if (!wr) chk(cfgRsp.rdata, exp);
    chk({7'h00, cfgRspHub.ack}, 8'h01);
    if (!wr) chk(cfgRspHub.rdata, (a == OFF_SBUS || a == OFF_SUBBUS) ? RD_ABSENT : exp);
  endtask : cfg

  // write then read the same byte in the very next cycle
  task automatic cfgPair(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(negedge sys_clk);
    cfgReq = '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    cfgReq = '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
    chk({7'h00, cfgRsp.ack}, 8'h01);
    @(negedge sys_clk);
    cfgReq.valid = 1'b0;
    chk({7'h00, cfgRsp.ack}, 8'h01);
    chk(cfgRsp.rdata, exp);
  endtask : cfgPair

  // downstream request; exp is {valid, hit, type1}
  task automatic fwd(input logic [7:0] b, input logic [2:0] exp);
    @(negedge sys_clk);
    fwdReq = '{valid: 1'b1, bus: b};
    @(negedge sys_clk);
    fwdReq.valid = 1'b0;
    chk({5'h00, fwdRsp}, {5'h00, exp});
    chk({5'h00, fwdRspHub}, {5'h00, exp[2], 2'b00});
  endtask : fwd

  task automatic finish_test();
    $display("errors=%0d checks=%0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    cfgReq = '0;
    fwdReq = '0;
    rst = 1'b1;
    nErrors = 0;
    checksDone = 0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    // reset value, write ff, read back per byte
    for (int i = 0; i < 6; i++) begin
      cfg(1'b0, offs[i], 8'h00, 8'h00);
      cfg(1'b1, offs[i], 8'hff, 8'h00);
      cfg(1'b0, offs[i], 8'h00, wExp[i]);
    end
    chk(cacheLineSize, 8'hff);
    // mixed bit pattern 5a catches a stuck or swapped bit
    cfg(1'b1, OFF_LINESZ, 8'h5a, 8'h00);
    cfg(1'b0, OFF_LINESZ, 8'h00, 8'h5a);
    chk(cacheLineSize, 8'h5a);
    // absent locations drop writes and read zero
    foreach (gaps[i]) begin
      cfg(1'b1, gaps[i], 8'ha5, 8'h00);
      cfg(1'b0, gaps[i], 8'h00, RD_ABSENT);
    end
    // gap writes must not have landed in the cache line size byte
    chk(cacheLineSize, 8'h5a);
    chk(cacheLineSizeHub, 8'h5a);
    // back-to-back write and read
    cfgPair(OFF_LINESZ, 8'hc3, 8'hc3);
    cfgPair(OFF_SELFTST, 8'hff, HW_SELFTST);
    // window 02..05, both edges and one outside each side
    cfg(1'b1, OFF_SBUS, 8'h02, 8'h00);
    cfg(1'b1, OFF_SUBBUS, 8'h05, 8'h00);
    fwd(8'h01, 3'b100);
    fwd(8'h02, 3'b110);
    fwd(8'h04, 3'b111);
    fwd(8'h05, 3'b111);
    fwd(8'h06, 3'b100);
    // subordinate below secondary leaves an empty window
    cfg(1'b1, OFF_SUBBUS, 8'h01, 8'h00);
    fwd(8'h02, 3'b100);
    // second reset mid-run clears the writable bytes
    @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk(cacheLineSize, RST_LINESZ);
    cfg(1'b0, OFF_LINESZ, 8'h00, RST_LINESZ);
    cfg(1'b0, OFF_SBUS, 8'h00, RST_SBUS);
    cfg(1'b0, OFF_SUBBUS, 8'h00, RST_SUBBUS);
    finish_test();
  end

  // watchdog: the sequence needs about 124 cycles, allow 10000
  initial begin
    #200000;
    nErrors++;
    finish_test();
  end

endmodule : bchr_regs_bench

`default_nettype wire
